// [mu_cfg.svh]
// mu_cfg.svh: fixed numbers of the multiply execution unit
// assumes: included by the unit's package only, by its bare name
`ifndef MU_CFG_SVH
`define MU_CFG_SVH

// datapath and tag widths
`define MU_DW           128
`define MU_TAG_W        6
`define MU_NOPS         11

// result pipeline depth: two beyond the longest latency
`define MU_SLOTS        8

// latencies in core cycles, issue edge to result-valid edge
`define MU_LAT_W8       4
`define MU_LAT_W16      4
`define MU_LAT_W32      3
`define MU_LAT_W64      5
`define MU_LAT_T16      4
`define MU_LAT_T32      3
`define MU_LAT_T64      5
`define MU_LAT_PMUL     4
`define MU_LAT_PLD      5
`define MU_LAT_MULPD    4
`define MU_LAT_CLMUL    6

// issue intervals in cycles
`define MU_IVL_PLD      2
`define MU_IVL_CLMUL    4

// microcode step codes and flow length
`define MU_STEP_EXT     2'h0
`define MU_STEP_MUL     2'h1
`define MU_STEP_END     2'h2
`define MU_FLOW_LEN     3

// first slot index that still belongs to a running microcode flow
`define MU_UC_BUSY_SLOT 2

// double-precision layout
`define MU_DP_BIAS      14'h03FF
`define MU_DP_EMAX      14'h07FF

`endif

// [mu_pkg.sv]
// mu_pkg: types shared by the multiply unit and its microcode sequencer
// assumes: mu_cfg.svh sits in the same folder
`include "mu_cfg.svh"

package mu_pkg;

    typedef enum logic [3:0] {
        MU_OP_W8,
        MU_OP_W16,
        MU_OP_W32,
        MU_OP_W64,
        MU_OP_T16,
        MU_OP_T32,
        MU_OP_T64,
        MU_OP_PMUL,
        MU_OP_PLD,
        MU_OP_MULPD,
        MU_OP_CLMUL
    } mu_op_t;

    typedef struct packed {
        logic                  vld;
        mu_op_t                op;
        logic                  sgn;
        logic [`MU_TAG_W-1:0]  tag;
        logic [`MU_DW-1:0]     a;
        logic [`MU_DW-1:0]     b;
    } mu_req_t;

    typedef struct packed {
        logic                  vld;
        logic [`MU_TAG_W-1:0]  tag;
        logic [`MU_DW-1:0]     data;
    } mu_res_t;

    typedef struct packed {
        logic                  vld;
        logic                  uc;
        logic [`MU_TAG_W-1:0]  tag;
        logic [`MU_DW-1:0]     data;
    } mu_slot_t;

    typedef struct packed {
        mu_slot_t [`MU_SLOTS-1:0] pipe;
        logic [1:0]               ivl_pld;
        logic [1:0]               ivl_clmul;
        logic [`MU_NOPS-1:0]      rdy;
    } mu_state_t;

    typedef struct packed {
        logic        run;
        logic [1:0]  pc;
        mu_op_t      op;
        logic        sgn;
        logic [15:0] a;
        logic [15:0] b;
        logic [31:0] ea;
        logic [31:0] eb;
        logic [31:0] prod;
        logic        done;
        logic [31:0] res;
    } mu_seq_t;

endpackage

// [mu_useq.sv]
// mu_useq: microcode sequencer for the narrow multiply forms
// assumes: start only while idle; one flow of three steps from its store
`timescale 1ns/1ns

module mu_useq
    import mu_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // flow start
    input  wire logic        start,
    input  wire mu_op_t      op,
    input  wire logic        sgn,
    input  wire logic [15:0] a,
    input  wire logic [15:0] b,
    // flow result
    output logic             done,
    output logic [31:0]      res
);

    // microcode_sequence_store: the step words of the multiply flow
    localparam logic [1:0] FLOW [0:`MU_FLOW_LEN-1] =
        '{`MU_STEP_EXT, `MU_STEP_MUL, `MU_STEP_END};

    mu_seq_t s_r;
    mu_seq_t s_nxt;

    function automatic logic [31:0] extend(input logic [15:0] x, input logic is8,
                                           input logic sg);
        logic [31:0] r;
        r = '0;
        if (is8) begin
            r = {{24{sg & x[7]}}, x[7:0]};
        end else begin
            r = {{16{sg & x[15]}}, x};
        end
        return r;
    endfunction

    always_comb begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        if (start && !s_r.run) begin
            s_nxt.run = 1'b1;
            s_nxt.pc  = 2'h0;
            s_nxt.op  = op;
            s_nxt.sgn = sgn;
            s_nxt.a   = a;
            s_nxt.b   = b;
        end else if (s_r.run) begin
            s_nxt.pc = s_r.pc + 2'h1;
            unique case (FLOW[s_r.pc])
                `MU_STEP_EXT: begin
                    s_nxt.ea = extend(s_r.a, s_r.op == MU_OP_W8, s_r.sgn);
                    s_nxt.eb = extend(s_r.b, s_r.op == MU_OP_W8, s_r.sgn);
                end
                `MU_STEP_MUL: begin
                    s_nxt.prod = s_r.ea * s_r.eb;
                end
                `MU_STEP_END: begin
                    unique case (s_r.op)
                        MU_OP_W8:  s_nxt.res = {16'h0000, s_r.prod[15:0]};
                        MU_OP_W16: s_nxt.res = s_r.prod;
                        default:   s_nxt.res = {16'h0000, s_r.prod[15:0]};
                    endcase
                    s_nxt.done = 1'b1;
                    s_nxt.run  = 1'b0;
                end
                // unused step code: abandon the flow
                default: begin
                    s_nxt.run = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign done = s_r.done;
    assign res  = s_r.res;

endmodule // mu_useq

// [mu_unit.sv]
// mu_unit: multiply execution unit, scalar, packed, double and carry-less
// assumes: scheduler issues an op only while its ready bit is high
`timescale 1ns/1ns

// Behaviour
// - common multiplies run without microcode
// - widening forms double width, fixed latencies
// - microcode forms step through stored flow
// - 16-bit truncating form: 4 cycles, microcode
// - 32-bit truncating form: 3 cycles, hardware
// - 64-bit truncating form: 5 cycles, hardware
// - packed integer: latency 4, every cycle
// - packed dword low: latency 5, every 2
// - packed double: latency 4, every cycle
// - carry-less: latency 6, every 4
module mu_unit
    import mu_pkg::*;
(
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                resetn,
    // issue from scheduler
    input  wire mu_req_t             req,
    output logic [`MU_NOPS-1:0]      rdy,
    // result and wake-up
    output mu_res_t                  res
);

    mu_state_t s_r;
    mu_state_t s_nxt;

    logic        take;
    logic        seq_start;
    logic        seq_done;
    logic [31:0] seq_res;

    function automatic int lat(input mu_op_t o);
        int l;
        l = 0;
        unique case (o)
            MU_OP_W8:    l = `MU_LAT_W8;
            MU_OP_W16:   l = `MU_LAT_W16;
            MU_OP_W32:   l = `MU_LAT_W32;
            MU_OP_W64:   l = `MU_LAT_W64;
            MU_OP_T16:   l = `MU_LAT_T16;
            MU_OP_T32:   l = `MU_LAT_T32;
            MU_OP_T64:   l = `MU_LAT_T64;
            MU_OP_PMUL:  l = `MU_LAT_PMUL;
            MU_OP_PLD:   l = `MU_LAT_PLD;
            MU_OP_MULPD: l = `MU_LAT_MULPD;
            MU_OP_CLMUL: l = `MU_LAT_CLMUL;
        endcase
        return l;
    endfunction

    function automatic logic is_uc(input mu_op_t o);
        return (o == MU_OP_W8) || (o == MU_OP_W16) || (o == MU_OP_T16);
    endfunction

    // sign or zero extension of the low w bits to full width
    function automatic logic [127:0] ext(input logic [63:0] x, input int w, input logic sg);
        logic [127:0] r;
        r = '0;
        if (w == 32) begin
            r = {{96{sg & x[31]}}, x[31:0]};
        end else begin
            r = {{64{sg & x[63]}}, x};
        end
        return r;
    endfunction

    // double multiply: truncating, flush of tiny results, no nan handling
    function automatic logic [63:0] dmul(input logic [63:0] x, input logic [63:0] y);
        logic               sg;
        logic [105:0]       p;
        logic signed [13:0] e;
        logic [51:0]        m;
        logic [63:0]        r;
        sg = x[63] ^ y[63];
        p  = {1'b1, x[51:0]} * {1'b1, y[51:0]};
        e  = $signed({3'h0, x[62:52]}) + $signed({3'h0, y[62:52]})
             - $signed(`MU_DP_BIAS);
        m  = p[103:52];
        if (p[105]) begin
            m = p[104:53];
            e = e + 14'sh0001;
        end
        r = {sg, e[10:0], m};
        if (x[62:52] == 11'h000 || y[62:52] == 11'h000 || e <= 14'sh0000) begin
            r = {sg, 63'h0};
        end else if (e >= $signed(`MU_DP_EMAX)) begin
            r = {sg, 11'h7FF, 52'h0};
        end
        return r;
    endfunction

    function automatic logic [127:0] clmul(input logic [63:0] x, input logic [63:0] y);
        logic [127:0] r;
        r = '0;
        for (int i = 0; i < 64; i++) begin
            if (y[i]) begin
                r = r ^ ({64'h0, x} << i);
            end
        end
        return r;
    endfunction

    function automatic logic [127:0] hw_mul(input mu_req_t q);
        logic [127:0] r;
        logic [127:0] p;
        r = '0;
        p = '0;
        unique case (q.op)
            MU_OP_W32: begin
                p = ext(q.a[63:0], 32, q.sgn) * ext(q.b[63:0], 32, q.sgn);
                r = {64'h0, p[63:0]};
            end
            MU_OP_W64: begin
                r = ext(q.a[63:0], 64, q.sgn) * ext(q.b[63:0], 64, q.sgn);
            end
            MU_OP_T32: begin
                p = ext(q.a[63:0], 32, q.sgn) * ext(q.b[63:0], 32, q.sgn);
                r = {96'h0, p[31:0]};
            end
            MU_OP_T64: begin
                p = ext(q.a[63:0], 64, q.sgn) * ext(q.b[63:0], 64, q.sgn);
                r = {64'h0, p[63:0]};
            end
            MU_OP_PMUL: begin
                for (int i = 0; i < 8; i++) begin
                    r[i*16 +: 16] = q.a[i*16 +: 16] * q.b[i*16 +: 16];
                end
            end
            MU_OP_PLD: begin
                for (int i = 0; i < 4; i++) begin
                    r[i*32 +: 32] = q.a[i*32 +: 32] * q.b[i*32 +: 32];
                end
            end
            MU_OP_MULPD: begin
                r = {dmul(q.a[127:64], q.b[127:64]), dmul(q.a[63:0], q.b[63:0])};
            end
            MU_OP_CLMUL: begin
                r = clmul(q.a[63:0], q.b[63:0]);
            end
            default: begin
                r = '0;
            end
        endcase
        return r;
    endfunction

    assign take      = req.vld && s_r.rdy[req.op];
    assign seq_start = take && is_uc(req.op);

    mu_useq u_useq (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .start   (seq_start),
        .op      (req.op),
        .sgn     (req.sgn),
        .a       (req.a[15:0]),
        .b       (req.b[15:0]),
        .done    (seq_done),
        .res     (seq_res)
    );

    always_comb begin
        mu_op_t o;
        int     l;
        logic   ok;
        o = MU_OP_W8;
        l = 0;
        ok = 1'b0;
        s_nxt = s_r;
        for (int i = 0; i < `MU_SLOTS - 1; i++) begin
            s_nxt.pipe[i] = s_r.pipe[i+1];
        end
        s_nxt.pipe[`MU_SLOTS-1] = '0;
        // flow result lands on its reserved slot
        if (s_r.pipe[1].uc && seq_done) begin
            s_nxt.pipe[0].data = {96'h0, seq_res};
        end
        if (s_r.ivl_pld != 2'h0) begin
            s_nxt.ivl_pld = s_r.ivl_pld - 2'h1;
        end
        if (s_r.ivl_clmul != 2'h0) begin
            s_nxt.ivl_clmul = s_r.ivl_clmul - 2'h1;
        end
        if (take) begin
            l = lat(req.op);
            s_nxt.pipe[l].vld = 1'b1;
            s_nxt.pipe[l].uc  = is_uc(req.op);
            s_nxt.pipe[l].tag = req.tag;
            s_nxt.pipe[l].data = is_uc(req.op) ? '0 : hw_mul(req);
            if (req.op == MU_OP_PLD) begin
                s_nxt.ivl_pld = 2'(`MU_IVL_PLD - 1);
            end
            if (req.op == MU_OP_CLMUL) begin
                s_nxt.ivl_clmul = 2'(`MU_IVL_CLMUL - 1);
            end
        end
        // ready: free write-back slot, interval elapsed, sequencer free
        for (int k = 0; k < `MU_NOPS; k++) begin
            o  = mu_op_t'(k);
            l  = lat(o);
            ok = !s_nxt.pipe[l+1].vld;
            if (o == MU_OP_PLD && s_nxt.ivl_pld != 2'h0) begin
                ok = 1'b0;
            end
            if (o == MU_OP_CLMUL && s_nxt.ivl_clmul != 2'h0) begin
                ok = 1'b0;
            end
            if (is_uc(o)) begin
                for (int i = `MU_UC_BUSY_SLOT; i < `MU_SLOTS; i++) begin
                    if (s_nxt.pipe[i].uc) begin
                        ok = 1'b0;
                    end
                end
            end
            s_nxt.rdy[k] = ok;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign res.vld  = s_r.pipe[0].vld;
    assign res.tag  = s_r.pipe[0].tag;
    assign res.data = s_r.pipe[0].data;
    assign rdy      = s_r.rdy;

endmodule // mu_unit

// [mu_unit_checker.sv]
// mu_unit_checker: timing assertions for the multiply unit
// assumes: bound to mu_unit, sees only its ports, one core clock
`timescale 1ns/1ns

module mu_unit_checker
    import mu_pkg::*;
(
    // clock and reset
    input wire logic                clk_sys,
    input wire logic                resetn,
    // watched ports
    input wire mu_req_t             req,
    input wire logic [`MU_NOPS-1:0] rdy,
    input wire mu_res_t             res
);
    localparam int LAT [11] = '{4, 4, 3, 5, 4, 3, 5, 4, 5, 4, 6};
    logic       iss;
    logic [7:0] pend_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    assign iss = req.vld && rdy[req.op];

    // one bit per edge ahead: catches results with no issue behind them
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pend_r <= 8'h00;
        end else begin
            pend_r <= (pend_r >> 1) | (iss ? 8'(1 << LAT[req.op]) : 8'h00);
        end
    end

    property p_lat3;
        (iss && LAT[req.op] == 3) |-> ##4 (res.vld && res.tag == $past(req.tag, 4));
    endproperty
    a_lat3: assert property (p_lat3)
        else $error("3-cycle result missing or wrong tag");
    property p_lat4;
        (iss && LAT[req.op] == 4) |-> ##5 (res.vld && res.tag == $past(req.tag, 5));
    endproperty
    a_lat4: assert property (p_lat4)
        else $error("4-cycle result missing or wrong tag");
    property p_lat5;
        (iss && LAT[req.op] == 5) |-> ##6 (res.vld && res.tag == $past(req.tag, 6));
    endproperty
    a_lat5: assert property (p_lat5)
        else $error("5-cycle result missing or wrong tag");
    property p_lat6;
        (iss && LAT[req.op] == 6) |-> ##7 (res.vld && res.tag == $past(req.tag, 7));
    endproperty
    a_lat6: assert property (p_lat6)
        else $error("6-cycle result missing or wrong tag");
    property p_pend;
        res.vld == pend_r[0];
    endproperty
    a_pend: assert property (p_pend)
        else $error("result valid without matching issue");
    property p_pld;
        (iss && req.op == MU_OP_PLD) |=> !rdy[MU_OP_PLD];
    endproperty
    a_pld: assert property (p_pld)
        else $error("dword low multiply accepted too soon");
    property p_clm;
        (iss && req.op == MU_OP_CLMUL) |=> (!rdy[MU_OP_CLMUL]) [*3];
    endproperty
    a_clm: assert property (p_clm)
        else $error("carry-less multiply accepted too soon");
    property p_uc;
        (iss && req.op inside {MU_OP_W8, MU_OP_W16, MU_OP_T16})
            |=> (!rdy[MU_OP_W8] && !rdy[MU_OP_W16] && !rdy[MU_OP_T16]) [*3];
    endproperty
    a_uc: assert property (p_uc)
        else $error("microcode form accepted during running flow");

endmodule // mu_unit_checker

bind mu_unit mu_unit_checker i_mu_unit_checker (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .req     (req),
    .rdy     (rdy),
    .res     (res)
);

// [mu_sched_model.sv]
// mu_sched_model: scheduler model, issues queued ops in order
// assumes: pushes arrive away from the rising edge
`timescale 1ns/1ns

module mu_sched_model
    import mu_pkg::*;
(
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                resetn,
    // issue towards the unit
    input  wire logic [`MU_NOPS-1:0] rdy,
    output mu_req_t                  req,
    output logic                     idle
);
    mu_req_t q [$];
    mu_req_t nxt;

    task automatic push(input mu_req_t r);
        q.push_back(r);
    endtask

    initial begin
        req = '0;
        idle = 1'b1;
    end

    // request held until taken; idle fields toggle so stale values never match
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            q.delete();
            req <= '0;
            idle <= 1'b1;
        end else begin
            if (req.vld && rdy[req.op]) begin
                void'(q.pop_front());
            end
            nxt = mu_req_t'(~req);
            nxt.vld = 1'b0;
            if (q.size() != 0) begin
                nxt = q[0];
            end
            req <= nxt;
            idle <= (q.size() == 0);
        end
    end

endmodule // mu_sched_model

// [test_multiply_execution_unit.sv]
// test_multiply_execution_unit: random and corner tests of the multiply unit
// assumes: scheduler model on the issue side, checker bound to the unit
`timescale 1ns/1ns

module test_multiply_execution_unit
    import mu_pkg::*;
;
    localparam int LAT [11] = '{4, 4, 3, 5, 4, 3, 5, 4, 5, 4, 6};
    logic                clk_sys;
    logic                resetn;
    mu_req_t             req;
    logic [`MU_NOPS-1:0] rdy;
    mu_res_t             res;
    logic                idle;
    int                  mismatches, cmp_count, cyc, outst;
    int                  exp_c [64];
    logic [127:0]        exp_d [64];
    int                  last [11];
    int                  gap [11];
    logic [5:0]          tag_c;
    mu_op_t              op;
    mu_op_t              sop [6] = '{MU_OP_PLD, MU_OP_CLMUL, MU_OP_W8, MU_OP_PMUL,
                                     MU_OP_MULPD, MU_OP_T32};
    int                  sgap [6] = '{2, 4, 4, 1, 1, 1};

    mu_unit i_mu_unit (.clk_sys(clk_sys), .resetn(resetn), .req(req), .rdy(rdy), .res(res));
    mu_sched_model i_mu_sched_model (.clk_sys(clk_sys), .resetn(resetn), .rdy(rdy),
                                     .req(req), .idle(idle));

    function automatic logic [127:0] ext(input logic [127:0] v, input int w, input logic s);
        logic [127:0] m;
        m = (128'h1 << w) - 128'h1;
        return (s && v[w-1]) ? (v | ~m) : (v & m);
    endfunction

    function automatic logic [127:0] exp_of(input mu_req_t r);
        logic [127:0] p;
        int           w;
        p = '0;
        w = (r.op == MU_OP_W8) ? 8 : (r.op inside {MU_OP_W16, MU_OP_T16}) ? 16 :
            (r.op inside {MU_OP_W32, MU_OP_T32}) ? 32 : 64;
        case (r.op)
            MU_OP_PMUL: for (int i = 0; i < 8; i++) p[16*i +: 16] = r.a[16*i +: 16] * r.b[16*i +: 16];
            MU_OP_PLD: for (int i = 0; i < 4; i++) p[32*i +: 32] = r.a[32*i +: 32] * r.b[32*i +: 32];
            MU_OP_MULPD: p = {2{64'h4018000000000000}};
            MU_OP_CLMUL: for (int i = 0; i < 64; i++) if (r.b[i]) p = p ^ (128'(r.a[63:0]) << i);
            default: begin
                p = ext(r.a, w, r.sgn) * ext(r.b, w, r.sgn);
                if (r.op inside {MU_OP_T16, MU_OP_T32, MU_OP_T64}) p = ext(p, w, 1'b0);
                else if (w < 64) p = ext(p, 2 * w, 1'b0);
            end
        endcase
        return p;
    endfunction

    task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] s);
        cmp_count++;
        if (s !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic give_verdict;
        $display("counts: %0d mismatches, %0d comparisons", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // double-precision operands kept exact so the product needs no rounding
    task automatic issue(input mu_op_t o, input logic [127:0] a, input logic [127:0] b,
                         input logic s);
        mu_req_t r;
        @(negedge clk_sys);
        r.vld = 1'b1;
        r.op = o;
        r.sgn = s;
        r.tag = tag_c;
        r.a = (o == MU_OP_MULPD) ? {2{64'h4000000000000000}} : a;
        r.b = (o == MU_OP_MULPD) ? {2{64'h4008000000000000}} : b;
        exp_d[tag_c] = exp_of(r);
        tag_c++;
        i_mu_sched_model.push(r);
    endtask

    task automatic drain;
        for (int k = 0; k < 400 && !(idle === 1'b1 && outst == 0); k++) @(posedge clk_sys);
        chk("drained", 128'h1, 128'(idle === 1'b1 && outst == 0));
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (resetn && req.vld && rdy[req.op]) begin
            exp_c[req.tag] = cyc + LAT[req.op] + 1;
            gap[req.op] = cyc - last[req.op];
            last[req.op] = cyc;
            outst = outst + 1;
        end
        if (resetn && res.vld === 1'b1) begin
            chk("latency", 128'(exp_c[res.tag]), 128'(cyc));
            chk("data", exp_d[res.tag], res.data);
            outst = outst - 1;
        end
    end

    initial begin
        #160000;
        mismatches++;
        give_verdict;
    end

    initial begin
        mismatches = 0;
        cmp_count = 0;
        cyc = 0;
        outst = 0;
        tag_c = 6'h00;
        resetn = 1'b0;
        void'($urandom(55709));
        repeat (6) @(posedge clk_sys);
        chk("ready in reset", 128'(rdy), 128'h0);
        resetn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        chk("ready after reset", 128'(rdy), 128'h7FF);
        issue(MU_OP_T32, 128'h3, 128'h7, 1'b0);
        issue(MU_OP_W8, '1, '1, 1'b1);
        issue(MU_OP_W8, 128'hFF, 128'hFF, 1'b0);
        issue(MU_OP_W64, '1, '1, 1'b0);
        issue(MU_OP_W64, '1, 128'h2, 1'b1);
        issue(MU_OP_T16, 128'h8000, 128'hFFFF, 1'b1);
        drain;
        $display("test corners done");
        for (int i = 0; i < 60; i++) begin
            op = mu_op_t'($urandom_range(10));
            issue(op, {$urandom, $urandom, $urandom, $urandom},
                  {$urandom, $urandom, $urandom, $urandom}, 1'($urandom_range(1)));
        end
        drain;
        $display("test random done");
        for (int s = 0; s < 6; s++) begin
            repeat (4) issue(sop[s], {$urandom, $urandom, $urandom, $urandom},
                             {4{$urandom}}, 1'b1);
            drain;
            chk("issue gap", 128'(gap[sop[s]]), 128'(sgap[s]));
        end
        $display("test streams done");
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk("ready in second reset", 128'(rdy), 128'h0);
        resetn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        issue(MU_OP_T64, {$urandom, $urandom, $urandom, $urandom}, {4{$urandom}}, 1'b0);
        drain;
        $display("test second reset done");
        give_verdict;
    end

endmodule // test_multiply_execution_unit
